// *** src/cmh_defines.vh ***
// constants for the mailbox message handler
`ifndef CMH_DEFINES_VH
`define CMH_DEFINES_VH
// geometry
`define CMH_NMB        16
`define CMH_IDW        29
`define CMH_STD_CARE   29'h1FFC0000
`define CMH_DLC_MAX    4'h8
`define CMH_RECESSIVE  4'hB
// register byte addresses
`define CMH_A_MCTRL    10'h000
`define CMH_A_STATUS   10'h004
`define CMH_A_IFLAGS   10'h008
`define CMH_A_GMASK    10'h00C
`define CMH_A_PEND     10'h010
`define CMH_A_CANCEL   10'h014
`define CMH_A_TXDONE   10'h018
`define CMH_A_ABORT    10'h01C
`define CMH_A_RXDONE   10'h020
`define CMH_A_REMOTE   10'h024
`define CMH_A_OVWR     10'h028
`define CMH_A_MBMASK   10'h02C
`define CMH_A_AMASK    10'h030
`define CMH_A_MBDIR    10'h034
// words inside one mailbox slot
`define CMH_MW_ID      2'h0
`define CMH_MW_DLC     2'h1
`define CMH_MW_DLO     2'h2
`define CMH_MW_DHI     2'h3
// fields
`define CMH_ID_IDE     31
`define CMH_ID_RTR     30
`define CMH_MC_HALT    0
`define CMH_MC_ORDER   1
`define CMH_MC_SLEEP   2
`define CMH_MC_WAKE    3
`define CMH_IF_RX      1
`define CMH_IF_RF      2
`define CMH_IF_EMPTY   8
`define CMH_IF_OVR     9
`define CMH_IF_BUS     12
// reset values and the transmit mailbox mask
`define CMH_MASK_RST   16'hFFFF
`define CMH_DIR_RST    16'h0001
`define CMH_TXMB_ONLY  16'hFFFE
`endif

// *** src/cmh_tx_select.v ***
// picks the next pending transmit mailbox by id or by number
`timescale 1ns/1ns
`include "cmh_defines.vh"
module cmh_tx_select (
  input  wire [15:0]  pend_i,
  input  wire [463:0] key_flat_i,
  input  wire         by_id_i,
  output reg          found_o,
  output reg  [3:0]   idx_o
);
  integer i;
  reg [28:0] best;

  // by id the lowest key wins, by number the lowest mailbox; ties go to the lower mailbox
  always @* begin
    found_o = 1'b0;
    idx_o   = 4'h0;
    best    = {`CMH_IDW{1'b1}};
    for (i = 1; i < `CMH_NMB; i = i + 1) begin
      if (pend_i[i] && (!found_o ||
          (by_id_i && key_flat_i[i*`CMH_IDW +: `CMH_IDW] < best))) begin
        found_o = 1'b1;
        idx_o   = i[3:0];
        best    = key_flat_i[i*`CMH_IDW +: `CMH_IDW];
      end
    end
  end
endmodule // cmh_tx_select

// *** src/cmh_rx_match.v ***
// identifier search over the receive mailboxes
`timescale 1ns/1ns
`include "cmh_defines.vh"
module cmh_rx_match (
  input  wire [28:0]  rx_id_i,
  input  wire         rx_ide_i,
  input  wire [463:0] id_flat_i,
  input  wire [15:0]  ide_i,
  input  wire [15:0]  rxdir_i,
  input  wire [28:0]  amask_i,
  output reg          hit0_o,
  output reg          hitn_o,
  output reg  [3:0]   idxn_o
);
  integer i;

  // standard frames compare only the top eleven bits
  function id_eq;
    input [28:0] a;
    input [28:0] b;
    input [28:0] m;
    input        ext;
    reg   [28:0] care;
    begin
      care  = ext ? ~m : (~m & `CMH_STD_CARE);
      id_eq = ((a ^ b) & care) == {`CMH_IDW{1'b0}};
    end
  endfunction

  // mailbox 0 masked, then first exact hit among 1..15
  always @* begin
    hit0_o = (ide_i[0] == rx_ide_i) &&
             id_eq(rx_id_i, id_flat_i[28:0], amask_i, rx_ide_i);
    hitn_o = 1'b0;
    idxn_o = 4'h0;
    for (i = 1; i < `CMH_NMB; i = i + 1) begin
      if (!hitn_o && rxdir_i[i] && ide_i[i] == rx_ide_i &&
          id_eq(rx_id_i, id_flat_i[i*`CMH_IDW +: `CMH_IDW],
                {`CMH_IDW{1'b0}}, rx_ide_i)) begin
        hitn_o = 1'b1;
        idxn_o = i[3:0];
      end
    end
  end
endmodule // cmh_rx_match

// *** src/cmh_core.v ***
// mailbox message handler core with avalon register slave
`timescale 1ns/1ns
`include "cmh_defines.vh"
module cmh_core (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  input  wire        ce_i,
  input  wire [9:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        can_rx_i,
  input  wire        bit_tick_i,
  input  wire        bus_idle_i,
  output reg         tx_req_o,
  output reg  [28:0] tx_id_o,
  output reg         tx_ide_o,
  output reg         tx_rtr_o,
  output reg  [3:0]  tx_dlc_o,
  output reg  [63:0] tx_data_o,
  input  wire        tx_done_i,
  input  wire        tx_retry_i,
  input  wire        rx_valid_i,
  input  wire        rx_crc_ok_i,
  input  wire [28:0] rx_id_i,
  input  wire        rx_ide_i,
  input  wire        rx_rtr_i,
  input  wire [3:0]  rx_dlc_i,
  input  wire [63:0] rx_data_i,
  output reg         ack_o,
  output reg         irq_o
);
  localparam ST_IDLE = 2'b00;
  localparam ST_SEL  = 2'b01;
  localparam ST_BUSY = 2'b10;

  integer i;
  reg [28:0] mb_id   [0:15];
  reg [15:0] mb_ide;
  reg [15:0] mb_rtr;
  reg [3:0]  mb_dlc  [0:15];
  reg [63:0] mb_data [0:15];
  reg [3:0]  master_control;
  reg [15:0] interrupt_flags;
  reg [15:0] global_int_mask;
  reg [15:0] per_mailbox_int_enable;
  reg [15:0] transmit_pending;
  reg [15:0] transmit_cancel_request;
  reg [15:0] transmit_done_flags;
  reg [15:0] abort_done_flags;
  reg [15:0] receive_complete_flags;
  reg [15:0] remote_request_pending;
  reg [15:0] unread_overwrite_flags;
  reg [28:0] acceptance_mask;
  reg [15:0] mailbox_dir;
  reg [1:0]  tx_state;
  reg [3:0]  tx_cur;
  reg        sleep_active;
  reg        halt_active;
  reg        bus_ready;
  reg        drop_first;
  reg [3:0]  rec_cnt;
  reg        rx_s1;
  reg        rx_s2;
  reg        rx_s3;
  reg        rx_lvl;
  reg        rx_lvl_q;
  reg [31:0] next_rdata;
  reg [463:0] id_flat;
  reg [463:0] key_flat;

  function [15:0] onehot;
    input [3:0] n;
    begin
      onehot = 16'h0001 << n;
    end
  endfunction

  // byte lanes past the coded length are forced to zero
  function [63:0] dlc_mask;
    input [3:0] dlc;
    reg   [3:0] n;
    begin
      n        = (dlc > `CMH_DLC_MAX) ? `CMH_DLC_MAX : dlc;
      dlc_mask = ~({64{1'b1}} << {n, 3'b000});
    end
  endfunction

  // bus side decode
  wire [9:0]  wa     = {avs_address_i[9:2], 2'b00};
  wire        is_mb  = (avs_address_i[9] ^ avs_address_i[8]) &
                       ~avs_address_i[4];
  wire [3:0]  mbi    = {avs_address_i[9], avs_address_i[7:5]};
  wire [1:0]  mbw    = avs_address_i[3:2];
  wire        wr_go  = avs_write_i & ~avs_waitrequest_o;
  wire [31:0] be     = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                        {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wd     = avs_writedata_i & be;
  wire [15:0] wd16   = wd[15:0];
  wire        w_mctl = wr_go & (wa == `CMH_A_MCTRL);
  wire        w_ifl  = wr_go & (wa == `CMH_A_IFLAGS);
  wire        w_gm   = wr_go & (wa == `CMH_A_GMASK);
  wire        w_pend = wr_go & (wa == `CMH_A_PEND);
  wire        w_canc = wr_go & (wa == `CMH_A_CANCEL);
  wire        w_txd  = wr_go & (wa == `CMH_A_TXDONE);
  wire        w_abd  = wr_go & (wa == `CMH_A_ABORT);
  wire        w_rxd  = wr_go & (wa == `CMH_A_RXDONE);
  wire        w_rem  = wr_go & (wa == `CMH_A_REMOTE);
  wire        w_ovw  = wr_go & (wa == `CMH_A_OVWR);
  wire        w_mbm  = wr_go & (wa == `CMH_A_MBMASK);
  wire        w_am   = wr_go & (wa == `CMH_A_AMASK);
  wire        w_dir  = wr_go & (wa == `CMH_A_MBDIR);
  wire        w_mb   = wr_go & is_mb;

  // transmit side: mailbox 0 and receive mailboxes never offered
  wire [15:0] tx_ok_mb = ~mailbox_dir & `CMH_TXMB_ONLY;
  wire        run      = bus_ready & ~sleep_active & ~halt_active;
  wire        sel_found;
  wire [3:0]  sel_idx;
  // cancels wait out internal arbitration; in the bus phase only the mailbox on the bus waits
  wire [15:0] canc_exec = (tx_state == ST_IDLE) ?
                          transmit_cancel_request & transmit_pending :
                          (tx_state == ST_BUSY) ?
                          transmit_cancel_request & transmit_pending &
                          ~onehot(tx_cur) : 16'h0000;
  wire [15:0] done_set  = (tx_state == ST_BUSY && tx_done_i) ?
                          onehot(tx_cur) : 16'h0000;
  wire [15:0] empty_ev  = (done_set | canc_exec) &
                          ~per_mailbox_int_enable;

  // receive side
  wire        hit0;
  wire        hitn;
  wire [3:0]  idxn;
  wire        rx_good  = rx_valid_i & rx_crc_ok_i;
  wire        store_ok = rx_good & run & ~drop_first;
  wire [15:0] store_v  = ({15'h0000, store_ok & hit0}) |
                         ((store_ok & hitn) ? onehot(idxn) : 16'h0000);
  wire [15:0] ovw_v    = store_v & receive_complete_flags;
  wire [15:0] rx_ev    = store_v & ~per_mailbox_int_enable;
  wire        wake_ev  = sleep_active & (rx_lvl != rx_lvl_q);

  // flatten mailbox ids; standard keys drop the unused low bits
  always @* begin
    id_flat  = {464{1'b0}};
    key_flat = {464{1'b0}};
    for (i = 0; i < `CMH_NMB; i = i + 1) begin
      id_flat[i*`CMH_IDW +: `CMH_IDW]  = mb_id[i];
      key_flat[i*`CMH_IDW +: `CMH_IDW] = mb_ide[i] ? mb_id[i] :
                                         (mb_id[i] & `CMH_STD_CARE);
    end
  end

  cmh_tx_select u_sel (
    .pend_i     (transmit_pending & tx_ok_mb & ~transmit_cancel_request),
    .key_flat_i (key_flat),
    .by_id_i    (~master_control[`CMH_MC_ORDER]),
    .found_o    (sel_found),
    .idx_o      (sel_idx)
  );

  cmh_rx_match u_match (
    .rx_id_i   (rx_id_i),
    .rx_ide_i  (rx_ide_i),
    .id_flat_i (id_flat),
    .ide_i     (mb_ide),
    .rxdir_i   (mailbox_dir),
    .amask_i   (acceptance_mask),
    .hit0_o    (hit0),
    .hitn_o    (hitn),
    .idxn_o    (idxn)
  );

  // pin synchroniser; level accepted once stages two and three agree
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_s3    <= 1'b1;
      rx_lvl   <= 1'b1;
      rx_lvl_q <= 1'b1;
    end else if (ce_i) begin
      rx_s1    <= can_rx_i;
      rx_s2    <= rx_s1;
      rx_s3    <= rx_s2;
      rx_lvl   <= (rx_s2 == rx_s3) ? rx_s3 : rx_lvl;
      rx_lvl_q <= rx_lvl;
    end
  end

  // read mux, unmapped addresses read zero
  always @* begin
    next_rdata = 32'h00000000;
    if (is_mb) begin
      case (mbw)
        `CMH_MW_ID:  next_rdata = {mb_ide[mbi], mb_rtr[mbi], 1'b0,
                                   mb_id[mbi]};
        `CMH_MW_DLC: next_rdata = {28'h0000000, mb_dlc[mbi]};
        `CMH_MW_DLO: next_rdata = mb_data[mbi][31:0];
        default:     next_rdata = mb_data[mbi][63:32];
      endcase
    end else begin
      case (wa)
        `CMH_A_MCTRL:  next_rdata = {28'h0000000, master_control};
        `CMH_A_STATUS: next_rdata = {28'h0000000, tx_state != ST_IDLE,
                                     bus_ready, sleep_active, halt_active};
        `CMH_A_IFLAGS: next_rdata = {16'h0000, interrupt_flags};
        `CMH_A_GMASK:  next_rdata = {16'h0000, global_int_mask};
        `CMH_A_PEND:   next_rdata = {16'h0000, transmit_pending};
        `CMH_A_CANCEL: next_rdata = {16'h0000, transmit_cancel_request};
        `CMH_A_TXDONE: next_rdata = {16'h0000, transmit_done_flags};
        `CMH_A_ABORT:  next_rdata = {16'h0000, abort_done_flags};
        `CMH_A_RXDONE: next_rdata = {16'h0000, receive_complete_flags};
        `CMH_A_REMOTE: next_rdata = {16'h0000, remote_request_pending};
        `CMH_A_OVWR:   next_rdata = {16'h0000, unread_overwrite_flags};
        `CMH_A_MBMASK: next_rdata = {16'h0000, per_mailbox_int_enable};
        `CMH_A_AMASK:  next_rdata = {3'b000, acceptance_mask};
        `CMH_A_MBDIR:  next_rdata = {16'h0000, mailbox_dir};
        default:       next_rdata = 32'h00000000;
      endcase
    end
  end

  // one wait cycle per access keeps read data a plain flop
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else if (ce_i) begin
      if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o    <= next_rdata;
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
    end
  end

  // mailbox storage: cpu write first, a received frame overrides
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      mb_ide <= 16'h0000;
      mb_rtr <= 16'h0000;
      for (i = 0; i < `CMH_NMB; i = i + 1) begin
        mb_id[i]   <= {`CMH_IDW{1'b0}};
        mb_dlc[i]  <= 4'h0;
        mb_data[i] <= 64'h0000000000000000;
      end
    end else if (ce_i) begin
      if (w_mb) begin
        case (mbw)
          `CMH_MW_ID: begin
            mb_id[mbi]  <= wd[28:0];
            mb_ide[mbi] <= wd[`CMH_ID_IDE];
            mb_rtr[mbi] <= wd[`CMH_ID_RTR];
          end
          `CMH_MW_DLC: mb_dlc[mbi] <= wd[3:0];
          `CMH_MW_DLO: mb_data[mbi][31:0] <=
                         (mb_data[mbi][31:0] & ~be) | wd;
          default:     mb_data[mbi][63:32] <=
                         (mb_data[mbi][63:32] & ~be) | wd;
        endcase
      end
      for (i = 0; i < `CMH_NMB; i = i + 1) begin
        if (store_v[i]) begin
          mb_id[i]   <= rx_id_i;
          mb_ide[i]  <= rx_ide_i;
          mb_rtr[i]  <= rx_rtr_i;
          mb_dlc[i]  <= rx_dlc_i;
          mb_data[i] <= rx_data_i;
        end
      end
    end
  end

  // control and flag registers; hardware sets win over software clears
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      master_control          <= 4'h0;
      interrupt_flags         <= 16'h0000;
      global_int_mask         <= `CMH_MASK_RST;
      per_mailbox_int_enable  <= `CMH_MASK_RST;
      transmit_pending        <= 16'h0000;
      transmit_cancel_request <= 16'h0000;
      transmit_done_flags     <= 16'h0000;
      abort_done_flags        <= 16'h0000;
      receive_complete_flags  <= 16'h0000;
      remote_request_pending  <= 16'h0000;
      unread_overwrite_flags  <= 16'h0000;
      acceptance_mask         <= {`CMH_IDW{1'b0}};
      mailbox_dir             <= `CMH_DIR_RST;
    end else if (ce_i) begin
      if (w_mctl)
        master_control <= wd[3:0];
      if (wake_ev && master_control[`CMH_MC_WAKE])
        master_control[`CMH_MC_SLEEP] <= 1'b0;
      if (w_gm)
        global_int_mask <= wd16;
      if (w_mbm)
        per_mailbox_int_enable <= wd16;
      if (w_am)
        acceptance_mask <= wd[28:0];
      if (w_dir)
        mailbox_dir <= wd16 | `CMH_DIR_RST;
      // writing zero leaves pending untouched; only a finished transmission, a cancel or a switch to receive removes it
      transmit_pending <= ((transmit_pending & ~done_set & ~canc_exec) |
                           (w_pend ? wd16 : 16'h0000)) & tx_ok_mb;
      transmit_cancel_request <= ((transmit_cancel_request & ~canc_exec) |
                                  (w_canc ? wd16 : 16'h0000)) &
                                 transmit_pending & tx_ok_mb;
      transmit_done_flags <= (transmit_done_flags &
                              ~(w_txd ? wd16 : 16'h0000)) | done_set;
      abort_done_flags <= (abort_done_flags &
                           ~(w_abd ? wd16 : 16'h0000)) | canc_exec;
      receive_complete_flags <= (receive_complete_flags &
                                 ~(w_rxd ? wd16 : 16'h0000)) | store_v;
      remote_request_pending <= (remote_request_pending &
                                 ~(w_rem ? wd16 : 16'h0000)) |
                                (store_v & {16{rx_rtr_i}});
      unread_overwrite_flags <= (unread_overwrite_flags &
                                 ~(w_ovw ? wd16 : 16'h0000)) | ovw_v;
      interrupt_flags <= interrupt_flags & ~(w_ifl ? wd16 : 16'h0000);
      if (|empty_ev)
        interrupt_flags[`CMH_IF_EMPTY] <= 1'b1;
      if (|rx_ev)
        interrupt_flags[`CMH_IF_RX] <= 1'b1;
      if (rx_rtr_i && |rx_ev)
        interrupt_flags[`CMH_IF_RF] <= 1'b1;
      if (|ovw_v)
        interrupt_flags[`CMH_IF_OVR] <= 1'b1;
      if (wake_ev)
        interrupt_flags[`CMH_IF_BUS] <= 1'b1;
    end
  end

  // transmit sequencer: select, load, wait for the engine's verdict
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_state  <= ST_IDLE;
      tx_cur    <= 4'h0;
      tx_req_o  <= 1'b0;
      tx_id_o   <= {`CMH_IDW{1'b0}};
      tx_ide_o  <= 1'b0;
      tx_rtr_o  <= 1'b0;
      tx_dlc_o  <= 4'h0;
      tx_data_o <= 64'h0000000000000000;
    end else if (ce_i) begin
      case (tx_state)
        ST_IDLE: begin
          if (run && sel_found) begin
            tx_cur   <= sel_idx;
            tx_state <= ST_SEL;
          end
        end
        ST_SEL: begin
          tx_id_o   <= key_flat[tx_cur*`CMH_IDW +: `CMH_IDW];
          tx_ide_o  <= mb_ide[tx_cur];
          tx_rtr_o  <= mb_rtr[tx_cur];
          tx_dlc_o  <= mb_dlc[tx_cur];
          tx_data_o <= mb_data[tx_cur] & dlc_mask(mb_dlc[tx_cur]);
          tx_req_o  <= 1'b1;
          tx_state  <= ST_BUSY;
        end
        ST_BUSY: begin
          // on a retry the mailbox stays pending and is picked again
          if (tx_done_i || tx_retry_i) begin
            tx_req_o <= 1'b0;
            tx_state <= ST_IDLE;
          end
        end
        default: tx_state <= ST_IDLE;
      endcase
    end
  end

  // sleep, halt and bus integration
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sleep_active <= 1'b0;
      halt_active  <= 1'b0;
      bus_ready    <= 1'b0;
      drop_first   <= 1'b0;
      rec_cnt      <= 4'h0;
    end else if (ce_i) begin
      if (!sleep_active && master_control[`CMH_MC_SLEEP] &&
          bus_idle_i && tx_state == ST_IDLE) begin
        sleep_active <= 1'b1;
        bus_ready    <= 1'b0;
      end else if (sleep_active &&
                   (!master_control[`CMH_MC_SLEEP] ||
                    (wake_ev && master_control[`CMH_MC_WAKE]))) begin
        sleep_active <= 1'b0;
        drop_first   <= wake_ev;
      end
      if (rx_valid_i)
        drop_first <= 1'b0;
      if (!halt_active && master_control[`CMH_MC_HALT] &&
          bus_idle_i && tx_state == ST_IDLE)
        halt_active <= 1'b1;
      else if (!master_control[`CMH_MC_HALT])
        halt_active <= 1'b0;
      // count recessive bits; a dominant bit restarts the run
      if (sleep_active || bus_ready || !rx_lvl)
        rec_cnt <= 4'h0;
      else if (bit_tick_i)
        rec_cnt <= rec_cnt + 4'h1;
      if (!sleep_active && rx_lvl && bit_tick_i &&
          rec_cnt == `CMH_RECESSIVE - 4'h1)
        bus_ready <= 1'b1;
    end
  end

  // acknowledge and interrupt outputs
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      ack_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= rx_good & ~sleep_active;
      irq_o <= |(interrupt_flags & ~global_int_mask);
    end
  end
endmodule // cmh_core

// *** tb/cmh_engine_model.sv ***
// protocol engine stand-in: bit ticks, idle, frame answers
`timescale 1ns/1ns
module cmh_engine_model (
  input  wire clk_i,
  input  wire reset_i,
  input  wire tx_req_i,
  output reg  bit_tick_o,
  output wire bus_idle_o,
  output wire can_rx_o,
  output reg  tx_done_o,
  output reg  tx_retry_o
);
  reg [3:0] cnt;
  reg       lost;
  // pin rests recessive; bus busy only while a frame is offered
  assign can_rx_o = 1'b1;
  assign bus_idle_o = !tx_req_i;
  // first offer loses arbitration once, later offers succeed
  always @(posedge clk_i) begin
    bit_tick_o <= (cnt[1:0] == 2'h3);
    tx_done_o <= 1'b0;
    tx_retry_o <= 1'b0;
    cnt <= reset_i ? 4'h0 : cnt + 4'h1;
    lost <= reset_i ? 1'b0 : lost;
    if (tx_req_i && !tx_done_o && !tx_retry_o && cnt == 4'hF) begin
      tx_retry_o <= !lost;
      tx_done_o <= lost;
      lost <= 1'b1;
    end
  end
endmodule // cmh_engine_model

// *** tb/cmh_core_asserts.sv ***
// link timing checks for the message handler core
`timescale 1ns/1ns
module cmh_core_asserts (
  input wire        clk_sys_i,
  input wire        reset_i,
  input wire        tx_req_o,
  input wire [28:0] tx_id_o,
  input wire        tx_ide_o,
  input wire [3:0]  tx_dlc_o,
  input wire [63:0] tx_data_o,
  input wire        tx_done_i,
  input wire        tx_retry_i,
  input wire        rx_valid_i,
  input wire        rx_crc_ok_i,
  input wire        ack_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  std_id_a: assert property (tx_req_o && !tx_ide_o |->
    tx_id_o[17:0] == 18'h0) else $error("std id low bits set");
  dlc_bytes_a: assert property (tx_req_o && tx_dlc_o < 4'h8 |->
    (tx_data_o >> {tx_dlc_o, 3'h0}) == 64'h0) else $error("extra bytes");
  done_drop_a: assert property (tx_req_o && tx_done_i |=>
    !tx_req_o) else $error("offer kept after done");
  retry_again_a: assert property (tx_req_o && tx_retry_i |=>
    !tx_req_o ##[1:8] tx_req_o) else $error("no retransmit");
  fields_hold_a: assert property (tx_req_o && !tx_done_i && !tx_retry_i
    |=> tx_req_o && $stable(tx_id_o) && $stable(tx_data_o))
    else $error("offer changed");
  tx_gap_a: assert property ($fell(tx_req_o) |-> !tx_req_o ##1
    !tx_req_o) else $error("offers too close");
  ack_cause_a: assert property (ack_o |->
    $past(rx_valid_i) && $past(rx_crc_ok_i)) else $error("ack without frame");
  bad_crc_a: assert property (rx_valid_i && !rx_crc_ok_i |=>
    !ack_o) else $error("ack on bad crc");
endmodule // cmh_core_asserts
bind cmh_core cmh_core_asserts cmh_core_asserts_inst (.*);

// *** tb/cmh_core_tb_top.sv ***
// self-checking bench for the mailbox message handler core
`timescale 1ns/1ns
`include "cmh_defines.vh"
module cmh_core_tb_top;
  reg         clk_sys_i = 1'b0, reset_i = 1'b1, rd_r = 1'b0, wr_r = 1'b0;
  reg         rx_valid = 1'b0, rx_crc = 1'b1, rx_rtr = 1'b0;
  reg  [9:0]  addr = 10'h000;
  reg  [31:0] wdata = 32'h0, got;
  reg  [28:0] rx_id = 29'h0;
  wire [31:0] rdata;
  wire        wreq, tx_req, tx_ide, tx_done, tx_retry, ack, irq, tick, idle;
  wire        pin, tx_rtr;
  wire [28:0] tx_id;
  wire [3:0]  tx_dlc;
  wire [63:0] tx_data;
  integer     miscompares = 0, n_compared = 0, i, k, n;
  reg  [41:0] rows [0:4];
  cmh_core cmh_core_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .ce_i(1'b1), .avs_address_i(addr), .avs_read_i(rd_r),
    .avs_write_i(wr_r), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .can_rx_i(pin),
    .bit_tick_i(tick), .bus_idle_i(idle), .tx_req_o(tx_req),
    .tx_id_o(tx_id), .tx_ide_o(tx_ide), .tx_rtr_o(tx_rtr), .tx_dlc_o(tx_dlc),
    .tx_data_o(tx_data), .tx_done_i(tx_done), .tx_retry_i(tx_retry),
    .rx_valid_i(rx_valid), .rx_crc_ok_i(rx_crc), .rx_id_i(rx_id),
    .rx_ide_i(1'b0), .rx_rtr_i(rx_rtr), .rx_dlc_i(4'h2),
    .rx_data_i(64'h5AA5), .ack_o(ack), .irq_o(irq));
  cmh_engine_model cmh_engine_model_inst (.clk_i(clk_sys_i),
    .reset_i(reset_i), .tx_req_i(tx_req), .bit_tick_o(tick),
    .bus_idle_o(idle), .can_rx_o(pin), .tx_done_o(tx_done),
    .tx_retry_o(tx_retry));
  // 100 MHz system clock
  initial begin
    forever #5 clk_sys_i = !clk_sys_i;
  end
  task tally_and_finish;
    begin
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  task chk(input [63:0] g, input [63:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // one avalon access; idle cycle after so strobes never re-assert in-step
  task bus(input w, input [9:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr_r <= w;
      rd_r <= !w;
      k = 0;
      @(posedge clk_sys_i);
      while (wreq !== 1'b0 && k < 40) begin
        @(posedge clk_sys_i);
        k = k + 1;
      end
      got = rdata;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      @(posedge clk_sys_i);
      if (k >= 40) begin
        miscompares = miscompares + 1;
        tally_and_finish;
      end
    end
  endtask
  task frame(input [28:0] id, input crc);
    begin
      rx_id <= id;
      rx_crc <= crc;
      rx_valid <= 1'b1;
      @(posedge clk_sys_i);
      rx_valid <= 1'b0;
      #1 chk(ack, crc);
      @(posedge clk_sys_i);
    end
  endtask
  // bounded wait for the next frame offer; running out ends the run
  task wait_req;
    begin
      for (i = 0; i < 200 && tx_req !== 1'b1; i = i + 1)
        @(posedge clk_sys_i);
      if (i >= 200) begin
        miscompares = miscompares + 1;
        tally_and_finish;
      end
    end
  endtask
  // poll pending until every queued mailbox has gone out
  task wait_idle;
    begin
      got = 32'h00000001;
      for (i = 0; i < 30 && got !== 32'h00000000; i = i + 1)
        bus(0, `CMH_A_PEND, 32'h00000000);
    end
  endtask
  // main sequence: resets, transmit, cancel under halt, receive, sleep
  initial begin
    rows[0] = {`CMH_A_GMASK, 32'h0000FFFF};
    rows[1] = {`CMH_A_MBMASK, 32'h0000FFFF};
    rows[2] = {`CMH_A_MBDIR, 32'h00000001};
    rows[3] = {`CMH_A_PEND, 32'h00000000};
    rows[4] = {10'h3F0, 32'h00000000};
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    bus(0, `CMH_A_STATUS, 0);
    chk(got, 0);
    $display("reset check done");
    repeat (100) @(posedge clk_sys_i);
    for (i = 0; i < 5; i = i + 1) begin
      bus(0, rows[i][41:32], 0);
      chk(got, rows[i][31:0]);
    end
    $display("register rows done");
    bus(1, 10'h120, 32'h9ABCDE12);
    bus(1, 10'h124, 32'h3);
    bus(1, 10'h128, 32'h44332211);
    bus(1, 10'h12C, 32'h88776655);
    bus(1, `CMH_A_PEND, 32'h3);
    wait_req;
    chk({tx_ide, tx_dlc, tx_id}, {1'b1, 4'h3, 29'h1ABCDE12});
    chk(tx_rtr, 1'h0);
    chk(tx_data, 64'h332211);
    wait_idle;
    chk(got, 0);
    bus(0, `CMH_A_TXDONE, 0);
    chk(got, 32'h2);
    $display("transmit done");
    bus(1, `CMH_A_MCTRL, 32'h1);
    bus(0, `CMH_A_STATUS, 0);
    chk(got, 32'h5);
    bus(1, `CMH_A_PEND, 32'h2);
    bus(1, `CMH_A_PEND, 32'h0);
    bus(0, `CMH_A_PEND, 0);
    chk(got, 32'h2);
    bus(1, `CMH_A_CANCEL, 32'h3);
    bus(0, `CMH_A_PEND, 0);
    chk(got, 0);
    bus(0, `CMH_A_ABORT, 0);
    chk(got, 32'h2);
    bus(1, `CMH_A_MCTRL, 32'h0);
    bus(0, `CMH_A_STATUS, 0);
    chk({tx_req, got}, 33'h4);
    $display("cancel done");
    // two pending: lowest id first, then lowest mailbox first
    bus(1, 10'h140, 32'h80000005);
    for (n = 0; n < 2; n = n + 1) begin
      bus(1, `CMH_A_MCTRL, {30'h00000000, n[0], 1'b0});
      bus(1, `CMH_A_PEND, 32'h00000006);
      wait_req;
      chk(tx_id, n ? 29'h1ABCDE12 : 29'h00000005);
      wait_idle;
      chk(got, 32'h00000000);
    end
    $display("order done");
    bus(1, `CMH_A_MBDIR, 32'h9);
    bus(1, 10'h100, 32'h0AA80000);
    bus(1, `CMH_A_AMASK, 32'h000C0000);
    bus(1, 10'h160, 32'h0AAC0000);
    bus(1, `CMH_A_GMASK, 32'hFFFD);
    bus(1, `CMH_A_MBMASK, 32'h0);
    frame(29'h0AAC0000, 1);
    bus(0, `CMH_A_RXDONE, 0);
    chk({irq, got}, 33'h100000009);
    bus(0, 10'h164, 32'h00000000);
    chk(got, 32'h00000002);
    bus(0, 10'h168, 32'h00000000);
    chk(got, 32'h00005AA5);
    rx_rtr <= 1'b1;
    frame(29'h0AAC0000, 1);
    frame(29'h0AAC0000, 0);
    bus(0, `CMH_A_OVWR, 0);
    chk(got, 32'h9);
    bus(0, `CMH_A_REMOTE, 0);
    chk(got, 32'h9);
    bus(1, `CMH_A_RXDONE, 32'hFFFF);
    frame(29'h0AB00000, 1);
    bus(0, `CMH_A_RXDONE, 0);
    chk(got, 0);
    $display("receive done");
    // sleep entry drops bus_ready; leaving is immediate, bus_ready returns after eleven recessive bits
    bus(1, `CMH_A_MCTRL, 32'h00000004);
    bus(0, `CMH_A_STATUS, 32'h00000000);
    chk(got, 32'h00000002);
    bus(1, `CMH_A_MCTRL, 32'h00000000);
    bus(0, `CMH_A_STATUS, 32'h00000000);
    chk(got, 32'h00000000);
    repeat (100) @(posedge clk_sys_i);
    bus(0, `CMH_A_STATUS, 32'h00000000);
    chk(got, 32'h00000004);
    $display("sleep done");
    // reset in mid-run brings flags and masks back
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    bus(0, `CMH_A_GMASK, 32'h00000000);
    chk(got, 32'h0000FFFF);
    bus(0, `CMH_A_OVWR, 32'h00000000);
    chk({irq, got}, 33'h000000000);
    bus(0, `CMH_A_STATUS, 32'h00000000);
    chk(got, 32'h00000000);
    $display("mid-run reset done");
    tally_and_finish;
  end
endmodule // cmh_core_tb_top
